/* verilog/tcmp_timer.sv */
/*
 16-bit timer with two output compare channels, reached over AXI4-Lite.
 Assumes high bytes are written before low bytes; the
 prescaler is a plain divide-by-N tick.
*/
// Notes on behaviour
// - PWM modes write compares into buffer
// - normal and clear-on-match modes write directly
// - buffer copies to active at TOP/BOTTOM
// - compare values change by processor writes or buffer copies
// - compare reads bypass the staging byte
// - high byte staged until low byte write
// - low write merges staged high, same cycle
// - force strobe acts like match outside PWM modes, no flag
// - counter write blocks next tick's matches
// - counter written at TOP runs to max
// - output bit survives mode changes
// - action select takes effect immediately
// - action select sets pin override, not the output bit
// - reset clears output bit
// - normal mode counts up, wraps at max
// - overflow flag set as counter passes max (fast PWM: at TOP, dual-slope: at BOTTOM)
// - interrupt service clears overflow flag
// - normal mode accepts counter writes anytime
// - clear-on-match uses compare A or capture
// - equality sets match flag next tick
// - match flag cleared by service or one
`timescale 1ns/1ps
module tcmp_timer
#(
   parameter int PRESC_W = 8
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // AXI4-Lite register bus
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Interrupt service acknowledges
   input  wire logic        overflow_ack,
   input  wire logic [1:0]  match_ack,
   // Flags and waveform pins
   output      logic        overflow_flag,
   output      logic [1:0]  match_flag,
   output      logic [1:0]  wave_out,
   output      logic [1:0]  wave_override
);
   import tcmp_pkg::*;

   if (PRESC_W < 1 || PRESC_W > 8)
   begin : g_chk
      $error("PRESC_W must lie in 1..8");
   end

   // ==========================================
   // Register access
   tcmp_bus_if bus ();

   tcmp_axi_slave u_axi
   (
      .clk           (clk),
      .reset         (reset),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .bus           (bus)
   );

   logic [7:0]         ctrl_ff;
   logic [PRESC_W-1:0] presc_ff;
   logic [PRESC_W-1:0] div_ff;
   logic [7:0]         temp_ff;
   logic [15:0]        cnt_ff;
   logic [15:0]        nxt_cnt;
   logic [15:0]        cap_ff;
   logic               dir_up_ff;
   logic               nxt_dir_up;
   logic               block_ff;
   logic [2:0]         flags_ff;
   logic [7:0]         rdata;

   wire wr_ctrl  = bus.wr && bus.waddr == OFF_CTRL;
   wire wr_force = bus.wr && bus.waddr == OFF_FORCE;
   wire wr_cnt_l = bus.wr && bus.waddr == OFF_CNT_L;
   wire wr_ca_l  = bus.wr && bus.waddr == OFF_CA_L;
   wire wr_cb_l  = bus.wr && bus.waddr == OFF_CB_L;
   wire wr_cap_l = bus.wr && bus.waddr == OFF_CAP_L;
   wire wr_flags = bus.wr && bus.waddr == OFF_FLAGS;
   wire wr_presc = bus.wr && bus.waddr == OFF_PRESC;
   wire wr_high  = bus.wr && (bus.waddr == OFF_CNT_H || bus.waddr == OFF_CA_H ||
                              bus.waddr == OFF_CB_H  || bus.waddr == OFF_CAP_H);
   // Low reads of the counter and capture registers latch the high byte
   wire rd_latch = bus.rd && (bus.raddr == OFF_CNT_L || bus.raddr == OFF_CAP_L);
   wire [15:0] wr_val = {temp_ff, bus.wdata};

   // ==========================================
   // Mode decode
   wire [3:0]  mode     = ctrl_ff[CTRL_MODE_LSB +: 4];
   wire        pwm      = tcmp_is_pwm(mode);
   wire        dual     = tcmp_is_dual(mode);
   wire        fast     = pwm && !dual;
   wire        upd_bot  = tcmp_upd_bottom(mode);
   wire tcmp_top_t tsel = tcmp_top_sel(mode);
   wire tcmp_act_t act_a = tcmp_act_t'(ctrl_ff[CTRL_ACTA_LSB +: 2]);
   wire tcmp_act_t act_b = tcmp_act_t'(ctrl_ff[CTRL_ACTB_LSB +: 2]);

   // ==========================================
   // Prescaler tick
   wire tick = (presc_ff != '0) && (div_ff == presc_ff - 1'b1);

   // ==========================================
   // Counter and compares
   logic [15:0] cmp_a;
   logic [15:0] cmp_b;
   logic [15:0] rb_a;
   logic [15:0] rb_b;
   logic [15:0] top_val;

   always_comb
   begin
      unique case (tsel)
         TOP_MAX:  top_val = CNT_MAX;
         TOP_8:    top_val = TOP_8BIT;
         TOP_9:    top_val = TOP_9BIT;
         TOP_10:   top_val = TOP_10BIT;
         TOP_CAP:  top_val = cap_ff;
         TOP_CMPA: top_val = cmp_a;
         default:  top_val = CNT_MAX;
      endcase
   end

   // Blocked ticks hide TOP too, so a written TOP runs on
   wire top_hit  = tick && !block_ff && cnt_ff == top_val;
   wire match_a  = tick && !block_ff && cnt_ff == cmp_a;
   wire match_b  = tick && !block_ff && cnt_ff == cmp_b;
   wire at_bot   = tick && !dir_up_ff && cnt_ff == CNT_BOTTOM;
   wire load_pt  = upd_bot ? at_bot : top_hit;
   wire fast_bot = fast && top_hit;
   wire ovf_set  = tick && ((!pwm && cnt_ff == CNT_MAX) || (fast && top_hit) ||
                            (dual && at_bot));
   wire force_a  = wr_force && !pwm && bus.wdata[0];
   wire force_b  = wr_force && !pwm && bus.wdata[1];

   always_comb
   begin
      nxt_cnt    = cnt_ff;
      nxt_dir_up = dir_up_ff;
      if (wr_cnt_l)
         nxt_cnt = wr_val;
      else if (tick)
      begin
         if (dual && dir_up_ff && top_hit)
         begin
            nxt_dir_up = 1'b0;
            nxt_cnt    = cnt_ff - 16'h0001;
         end
         else if (dual && !dir_up_ff)
         begin
            nxt_dir_up = (cnt_ff == CNT_BOTTOM);
            nxt_cnt    = nxt_dir_up ? cnt_ff + 16'h0001 : cnt_ff - 16'h0001;
         end
         else if (top_hit && mode != MODE_NORMAL)
            nxt_cnt = CNT_BOTTOM;
         else
            nxt_cnt = cnt_ff + 16'h0001;
      end
      if (!dual)
         nxt_dir_up = 1'b1;
   end

   tcmp_chan u_chan_a
   (
      .clk       (clk),
      .reset     (reset),
      .act       (act_a),
      .buffered  (pwm),
      .fast      (fast),
      .dual      (dual),
      .dir_up    (dir_up_ff),
      .load_pt   (load_pt),
      .match     (match_a),
      .force_ev  (force_a),
      .bottom_ev (fast_bot),
      .wr_low    (wr_ca_l),
      .wr_val    (wr_val),
      .active    (cmp_a),
      .readback  (rb_a),
      .wave      (wave_out[0])
   );

   tcmp_chan u_chan_b
   (
      .clk       (clk),
      .reset     (reset),
      .act       (act_b),
      .buffered  (pwm),
      .fast      (fast),
      .dual      (dual),
      .dir_up    (dir_up_ff),
      .load_pt   (load_pt),
      .match     (match_b),
      .force_ev  (force_b),
      .bottom_ev (fast_bot),
      .wr_low    (wr_cb_l),
      .wr_val    (wr_val),
      .active    (cmp_b),
      .readback  (rb_b),
      .wave      (wave_out[1])
   );

   // Any selected action takes over the pin
   assign wave_override[0] = act_a != ACT_OFF;
   assign wave_override[1] = act_b != ACT_OFF;

   // ==========================================
   // Flags: a set in the clearing cycle wins
   wire [2:0] flag_set = {match_b, match_a, ovf_set};
   wire [2:0] flag_w1c = wr_flags ? bus.wdata[2:0] : 3'h0;
   wire [2:0] flag_ack = {match_ack, overflow_ack};
   wire [2:0] nxt_flags = (flags_ff & ~(flag_w1c | flag_ack)) | flag_set;

   assign overflow_flag = flags_ff[FLAG_OVF];
   assign match_flag    = {flags_ff[FLAG_MB], flags_ff[FLAG_MA]};

   // ==========================================
   // Read mux
   always_comb
   begin
      unique case (bus.raddr)
         OFF_CTRL:  rdata = ctrl_ff;
         OFF_CNT_L: rdata = cnt_ff[7:0];
         OFF_CNT_H: rdata = temp_ff;
         OFF_CA_L:  rdata = rb_a[7:0];
         OFF_CA_H:  rdata = rb_a[15:8];
         OFF_CB_L:  rdata = rb_b[7:0];
         OFF_CB_H:  rdata = rb_b[15:8];
         OFF_CAP_L: rdata = cap_ff[7:0];
         OFF_CAP_H: rdata = temp_ff;
         OFF_FLAGS: rdata = {5'h00, flags_ff};
         OFF_PRESC: rdata = 8'(presc_ff);
         default:   rdata = 8'h00;
      endcase
   end
   assign bus.rdata = rdata;

   // ==========================================
   // State registers
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ctrl_ff   <= CTRL_RST;
         presc_ff  <= PRESC_W'(PRESC_RST);
         div_ff    <= '0;
         temp_ff   <= 8'h00;
         cnt_ff    <= CNT_BOTTOM;
         cap_ff    <= CNT_BOTTOM;
         dir_up_ff <= 1'b1;
         block_ff  <= 1'b0;
         flags_ff  <= 3'h0;
      end
      else
      begin
         cnt_ff    <= nxt_cnt;
         dir_up_ff <= nxt_dir_up;
         flags_ff  <= nxt_flags;
         // Block stays until a tick passes, even with the prescaler stopped
         if (wr_cnt_l)
            block_ff <= 1'b1;
         else if (tick)
            block_ff <= 1'b0;
         if (wr_presc || tick)
            div_ff <= '0;
         else if (presc_ff != '0)
            div_ff <= div_ff + 1'b1;
         if (wr_ctrl)
            ctrl_ff <= bus.wdata;
         if (wr_presc)
            presc_ff <= bus.wdata[PRESC_W-1:0];
         if (wr_cap_l)
            cap_ff <= wr_val;
         if (wr_high)
            temp_ff <= bus.wdata;
         else if (rd_latch)
            temp_ff <= (bus.raddr == OFF_CNT_L) ? cnt_ff[15:8] : cap_ff[15:8];
      end
   end
endmodule

/* verilog/tcmp_pkg.sv */
/*
 Constants and helpers for the 16-bit timer compare block.
 Assumes byte registers in bits 7:0 of aligned AXI words.
*/
package tcmp_pkg;
   // ==========================================
   // Register offsets and fields
   localparam logic [7:0] OFF_CTRL  = 8'h00;
   localparam logic [7:0] OFF_FORCE = 8'h04;
   localparam logic [7:0] OFF_CNT_L = 8'h08;
   localparam logic [7:0] OFF_CNT_H = 8'h0c;
   localparam logic [7:0] OFF_CA_L  = 8'h10;
   localparam logic [7:0] OFF_CA_H  = 8'h14;
   localparam logic [7:0] OFF_CB_L  = 8'h18;
   localparam logic [7:0] OFF_CB_H  = 8'h1c;
   localparam logic [7:0] OFF_CAP_L = 8'h20;
   localparam logic [7:0] OFF_CAP_H = 8'h24;
   localparam logic [7:0] OFF_FLAGS = 8'h28;
   localparam logic [7:0] OFF_PRESC = 8'h2c;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_ACTA_LSB = 4;
   localparam int CTRL_ACTB_LSB = 6;
   localparam int FLAG_OVF      = 0;
   localparam int FLAG_MA       = 1;
   localparam int FLAG_MB       = 2;
   localparam logic [7:0] CTRL_RST  = 8'h00;
   localparam logic [7:0] PRESC_RST = 8'h00;
   localparam logic       WAVE_RST  = 1'b0;
   // ==========================================
   // Count values and modes
   localparam logic [15:0] CNT_MAX    = 16'hffff;
   localparam logic [15:0] CNT_BOTTOM = 16'h0000;
   localparam logic [15:0] TOP_8BIT   = 16'h00ff;
   localparam logic [15:0] TOP_9BIT   = 16'h01ff;
   localparam logic [15:0] TOP_10BIT  = 16'h03ff;
   localparam logic [3:0]  MODE_NORMAL  = 4'h0;
   localparam logic [3:0]  MODE_CTC_A   = 4'h4;
   localparam logic [3:0]  MODE_CTC_CAP = 4'hc;
   localparam logic [3:0]  MODE_RSVD    = 4'hd;
   typedef enum logic [1:0] {ACT_OFF, ACT_TOGGLE, ACT_CLEAR, ACT_SET} tcmp_act_t;
   typedef enum logic [2:0] {TOP_MAX, TOP_8, TOP_9, TOP_10, TOP_CAP, TOP_CMPA} tcmp_top_t;
   // ==========================================
   // Mode decoding
   function automatic logic tcmp_is_pwm(input logic [3:0] m);
      return !(m == MODE_NORMAL || m == MODE_CTC_A || m == MODE_CTC_CAP || m == MODE_RSVD);
   endfunction
   function automatic logic tcmp_is_dual(input logic [3:0] m);
      return (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
   endfunction
   function automatic logic tcmp_upd_bottom(input logic [3:0] m);
      return (m == 4'h8 || m == 4'h9);
   endfunction
   function automatic tcmp_top_t tcmp_top_sel(input logic [3:0] m);
      tcmp_top_t t;
      t = TOP_MAX;
      if (m == 4'h1 || m == 4'h5) t = TOP_8;
      if (m == 4'h2 || m == 4'h6) t = TOP_9;
      if (m == 4'h3 || m == 4'h7) t = TOP_10;
      if (m inside {4'h8, 4'ha, 4'hc, 4'he}) t = TOP_CAP;
      if (m inside {4'h4, 4'h9, 4'hb, 4'hf}) t = TOP_CMPA;
      return t;
   endfunction
endpackage

/* verilog/tcmp_bus_if.sv */
/*
 Byte register access strobes between the AXI slave and the timer core.
 Assumes one clock; wr and rd are single-cycle pulses.
*/
`timescale 1ns/1ps
interface tcmp_bus_if;
   logic       wr;
   logic       rd;
   logic [7:0] waddr;
   logic [7:0] raddr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport slave (output wr, rd, waddr, raddr, wdata, input rdata);
   modport regs  (input wr, rd, waddr, raddr, wdata, output rdata);
endinterface

/* verilog/tcmp_axi_slave.sv */
/*
 AXI4-Lite slave turning bus transfers into byte register strobes.
 Assumes one write and one read outstanding at most.
*/
`timescale 1ns/1ps
module tcmp_axi_slave
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // AXI4-Lite
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Register strobes
   tcmp_bus_if.slave        bus
);
   logic [7:0] aw_addr_ff;
   logic       aw_ok_ff;
   logic [7:0] w_data_ff;
   logic       w_en_ff;
   logic       w_ok_ff;
   logic       bvalid_ff;
   logic [7:0] rdata_ff;
   logic       rvalid_ff;
   wire        aw_take = s_axi_awvalid && s_axi_awready;
   wire        w_take  = s_axi_wvalid && s_axi_wready;
   wire        wr_go   = aw_ok_ff && w_ok_ff && !bvalid_ff;
   wire        ar_take = s_axi_arvalid && s_axi_arready;

   assign s_axi_awready = !aw_ok_ff;
   assign s_axi_wready  = !w_ok_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = 2'h0;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rresp   = 2'h0;
   assign s_axi_rdata   = {24'h000000, rdata_ff};
   // Only byte lane 0 is used
   assign bus.wr    = wr_go && w_en_ff;
   assign bus.waddr = {aw_addr_ff[7:2], 2'h0};
   assign bus.wdata = w_data_ff;
   assign bus.rd    = ar_take;
   assign bus.raddr = {s_axi_araddr[7:2], 2'h0};

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         aw_ok_ff  <= 1'b0;
         w_ok_ff   <= 1'b0;
         bvalid_ff <= 1'b0;
         rvalid_ff <= 1'b0;
      end
      else
      begin
         aw_ok_ff  <= wr_go ? 1'b0 : (aw_ok_ff || aw_take);
         w_ok_ff   <= wr_go ? 1'b0 : (w_ok_ff || w_take);
         bvalid_ff <= wr_go || (bvalid_ff && !s_axi_bready);
         rvalid_ff <= ar_take || (rvalid_ff && !s_axi_rready);
      end
   end

   always_ff @(posedge clk)
   begin
      if (aw_take)
         aw_addr_ff <= s_axi_awaddr;
      if (w_take)
      begin
         w_data_ff <= s_axi_wdata[7:0];
         w_en_ff   <= s_axi_wstrb[0];
      end
      if (ar_take)
         rdata_ff <= bus.rdata;
   end
endmodule

/* verilog/tcmp_chan.sv */
/*
 One compare channel: buffered compare value and its waveform output bit.
 Assumes match and bottom events come gated by the timer tick; force events come straight from the bus write.
*/
`timescale 1ns/1ps
module tcmp_chan
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Mode and events
   input  wire tcmp_pkg::tcmp_act_t act,
   input  wire logic             buffered,
   input  wire logic             fast,
   input  wire logic             dual,
   input  wire logic             dir_up,
   input  wire logic             load_pt,
   input  wire logic             match,
   input  wire logic             force_ev,
   input  wire logic             bottom_ev,
   // Processor write
   input  wire logic             wr_low,
   input  wire logic [15:0]      wr_val,
   // Results
   output      logic [15:0]      active,
   output      logic [15:0]      readback,
   output      logic             wave
);
   import tcmp_pkg::*;
   logic [15:0] buf_ff;
   logic [15:0] act_ff;
   logic        wave_ff;
   logic        nxt_wave;
   wire         hit = match || force_ev;
   wire         on_match_lvl = dual ? !dir_up : 1'b0;

   assign active   = act_ff;
   assign readback = buffered ? buf_ff : act_ff;
   assign wave     = wave_ff;

   // Mode changes leave the bit alone
   always_comb
   begin
      nxt_wave = wave_ff;
      unique case (act)
         ACT_OFF:    nxt_wave = wave_ff;
         ACT_TOGGLE: nxt_wave = hit ? !wave_ff : wave_ff;
         ACT_CLEAR:
         begin
            if (hit)
               nxt_wave = on_match_lvl;
            else if (fast && bottom_ev)
               nxt_wave = 1'b1;
         end
         ACT_SET:
         begin
            if (hit)
               nxt_wave = !on_match_lvl;
            else if (fast && bottom_ev)
               nxt_wave = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         buf_ff  <= CNT_BOTTOM;
         act_ff  <= CNT_BOTTOM;
         wave_ff <= WAVE_RST;
      end
      else
      begin
         wave_ff <= nxt_wave;
         if (wr_low && buffered)
            buf_ff <= wr_val;
         if (wr_low && !buffered)
            act_ff <= wr_val;
         else if (buffered && load_pt)
            act_ff <= buf_ff;
      end
   end
endmodule

/* verification/tcmp_timer_checker.sv */
/*
 Port assertions for the timer compare block.
 Assumes a bind onto tcmp_timer.
*/
`timescale 1ns/1ps
module tcmp_timer_checker
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // Bus responses
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   // Timer pins
   input wire logic        overflow_ack,
   input wire logic [1:0]  match_ack,
   input wire logic        overflow_flag,
   input wire logic [1:0]  match_flag,
   input wire logic [1:0]  wave_out,
   input wire logic [1:0]  wave_override
);
   // ==========================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   AST_RST_OUT: assert property (disable iff (1'b0) reset |=> !overflow_flag && match_flag == 2'h0
      && wave_out == 2'h0 && wave_override == 2'h0) else $error("outputs not cleared by reset");
   AST_OVF_CLR: assert property ($fell(overflow_flag) |->
      $past(overflow_ack) || $rose(s_axi_bvalid) || $past(reset)) else $error("overflow flag lost");
   AST_MATCH_CLR: assert property (|($past(match_flag) & ~match_flag & ~$past(match_ack)) |->
      $rose(s_axi_bvalid) || $past(reset)) else $error("match flag lost");
   AST_OVR_CHG: assert property ($changed(wave_override) |->
      $rose(s_axi_bvalid) || $past(reset)) else $error("override moved without write");
   AST_BRESP: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0) else $error("bad write response");
   AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
   AST_BDROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
   AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   AST_RBYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rresp == 2'h0
      && !s_axi_arready) else $error("bad read beat");
   COV_OVF: cover property ($rose(overflow_flag));
   COV_MA: cover property ($rose(match_flag[0]));
   COV_WAVE: cover property ($changed(wave_out));
endmodule

bind tcmp_timer tcmp_timer_checker u_chk (.*);

/* verification/tcmp_irq_model.sv */
/*
 Processor interrupt service model: acks raised flags after a delay.
 Assumes level flags and one-cycle ack pulses.
*/
`timescale 1ns/1ps
module tcmp_irq_model
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Service control
   input  wire logic       en,
   input  wire logic [3:0] delay,
   // Timer flags and acks
   input  wire logic       overflow_flag,
   input  wire logic [1:0] match_flag,
   output      logic       overflow_ack,
   output      logic [1:0] match_ack,
   output      logic [7:0] n_ovf
);
   logic [2:0] ack_ff;
   logic [3:0] wait_ff;
   wire  [2:0] pend = en ? {match_flag, overflow_flag} : 3'h0;
   assign overflow_ack = ack_ff[0];
   assign match_ack = ack_ff[2:1];
   always_ff @(posedge clk)
   begin
      if (reset || pend == 3'h0)
      begin
         ack_ff <= 3'h0;
         wait_ff <= 4'h0;
         n_ovf <= reset ? 8'h00 : n_ovf;
      end
      else if (wait_ff < delay)
         wait_ff <= wait_ff + 4'h1;
      else
      begin
         // One pulse per flag
         ack_ff <= pend & ~ack_ff;
         n_ovf <= n_ovf + 8'(pend[0] & ~ack_ff[0]);
      end
   end
endmodule

/* verification/testbench.sv */
/*
 Self-checking bench for the timer compare block.
 Assumes the interrupt model acts as the processor's service routine.
*/
`timescale 1ns/1ps
module testbench;
   import tcmp_pkg::*;
   localparam logic [1:0] ACTS [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
   localparam logic       EXPW [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   localparam logic [3:0] CTC_M [2] = '{MODE_CTC_A, MODE_CTC_CAP};
   localparam logic [7:0] CTC_TOP [2] = '{8'h05, 8'h02};
   logic        clk, reset, overflow_ack, overflow_flag, irq_en;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, n_ovf, d;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, irq_dly;
   logic [1:0]  s_axi_bresp, s_axi_rresp, match_ack, match_flag, wave_out, wave_override;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int          n_errors, comparisons, t, i;

   tcmp_timer #(.PRESC_W(8)) DUT (.*);
   tcmp_irq_model u_cpu (.en(irq_en), .delay(irq_dly), .*);

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ==========================================
   // Bus tasks and checks
   task automatic final_report;
      $display("errors=%0d comparisons=%0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic lim(input int n, input int m);
      if (n >= m)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t wait got=%h exp=%h", $time, n, m);
         final_report();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      int   n;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      s_axi_bready <= 1'b0;
      lim(n, 40);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      int   n;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge clk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      v = s_axi_rdata[7:0];
      s_axi_rready <= 1'b0;
      lim(n, 40);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      rd(a, d);
      chk(16'(d), 16'(e));
   endtask
   task automatic wm(input int m, output int n);
      for (n = 0; n < m; n++)
      begin
         @(posedge clk);
         if (match_flag[0] === 1'b1) break;
      end
      lim(n, m);
   endtask

   // ==========================================
   // Test sequence
   initial
   begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, irq_dly} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, irq_en} = '0;
      s_axi_wstrb = 4'hf;
      reset = 1'b1;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      rc(OFF_CTRL, CTRL_RST);
      chk(16'(wave_out), 16'h0);
      chk(16'(wave_override), 16'h0);
      $display("test reset done");
      wr(OFF_CA_H, 8'h12);
      wr(OFF_CA_L, 8'h34);
      rc(OFF_CA_L, 8'h34);
      rc(OFF_CA_H, 8'h12);
      wr(OFF_CNT_H, 8'hab);
      wr(OFF_CNT_L, 8'hcd);
      rc(OFF_CNT_L, 8'hcd);
      rc(OFF_CA_H, 8'h12);
      $display("test compare access done");
      for (i = 0; i < 4; i++)
      begin
         wr(OFF_CTRL, {2'h0, ACTS[i], MODE_NORMAL});
         chk(16'(wave_override), 16'h1);
         wr(OFF_FORCE, 8'h01);
         chk(16'(wave_out), 16'(EXPW[i]));
         chk(16'(match_flag), 16'h0);
      end
      wr(OFF_CTRL, 8'hc0);
      wr(OFF_FORCE, 8'h02);
      chk(16'(wave_out), 16'h2);
      chk(16'(wave_override), 16'h2);
      wr(OFF_CTRL, 8'hd5);
      chk(16'(wave_out), 16'h2);
      wr(OFF_FORCE, 8'h01);
      chk(16'(wave_out), 16'h2);
      $display("test force done");
      wr(OFF_CTRL, 8'h00);
      wr(OFF_CA_H, 8'h00);
      wr(OFF_CA_L, 8'h40);
      wr(OFF_CTRL, 8'h05);
      wr(OFF_CA_H, 8'h00);
      wr(OFF_CA_L, 8'hf0);
      wr(OFF_CNT_H, 8'h00);
      wr(OFF_CNT_L, 8'h00);
      wr(OFF_FLAGS, 8'h07);
      wr(OFF_PRESC, 8'h01);
      wm(200, t);
      chk(16'(t < 'h80), 16'h1);
      wr(OFF_FLAGS, 8'h02);
      chk(16'(match_flag[0]), 16'h0);
      wm(600, t);
      chk(16'(t > 'h180), 16'h1);
      wr(OFF_PRESC, 8'h00);
      $display("test buffering done");
      wr(OFF_CTRL, 8'h00);
      wr(OFF_CA_L, 8'h05);
      wr(OFF_CNT_L, 8'h05);
      wr(OFF_FLAGS, 8'h07);
      wr(OFF_PRESC, 8'h01);
      repeat (20) @(posedge clk);
      chk(16'(match_flag[0]), 16'h0);
      wr(OFF_PRESC, 8'h00);
      wr(OFF_CNT_L, 8'h04);
      wr(OFF_PRESC, 8'h01);
      wm(20, t);
      wr(OFF_PRESC, 8'h00);
      $display("test blocking done");
      irq_en <= 1'b1;
      irq_dly <= 4'h3;
      wr(OFF_FLAGS, 8'h07);
      wr(OFF_CNT_H, 8'hff);
      wr(OFF_CNT_L, 8'hfd);
      wr(OFF_PRESC, 8'h01);
      for (t = 0; t < 60 && n_ovf == 8'h00; t++) @(posedge clk);
      lim(t, 60);
      repeat (2) @(posedge clk);
      chk(16'(overflow_flag), 16'h0);
      rd(OFF_CNT_L, d);
      chk(16'(d < 8'h40), 16'h1);
      rc(OFF_CNT_H, 8'h00);
      wr(OFF_PRESC, 8'h00);
      $display("test overflow done");
      wr(OFF_CAP_H, 8'h00);
      wr(OFF_CAP_L, 8'h02);
      for (i = 0; i < 2; i++)
      begin
         wr(OFF_CTRL, {4'h0, CTC_M[i]});
         wr(OFF_CNT_L, 8'h00);
         wr(OFF_PRESC, 8'h01);
         repeat (30) @(posedge clk);
         rd(OFF_CNT_L, d);
         chk(16'(d <= CTC_TOP[i]), 16'h1);
         wr(OFF_PRESC, 8'h00);
      end
      $display("test clear on match done");
      final_report();
   end
endmodule
